// File: pmc_far_end.sv
/*
  Far-end model: application processor and peripherals driving the
  keep-alive, low-power request and core scaling pins.
  Assumes the bench commands sleep, polarity and keep-alive loss.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_far_end (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_drop_keepalive,
  input wire logic i_proc_sleep,
  input wire logic i_peri_sleep,
  input wire logic i_pol_proc,
  input wire logic i_pol_peri,
  input wire logic [1:0] i_scale,
  output logic o_keepalive,
  output logic o_proc_req,
  output logic o_peri_req,
  output logic o_scale_one,
  output logic o_scale_two
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Pins move just after an edge, as a clocked processor would
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      o_keepalive <= 1'b0;
      o_proc_req <= 1'b0;
      o_peri_req <= 1'b0;
      o_scale_one <= 1'b0;
      o_scale_two <= 1'b0;
    end else begin
      o_keepalive <= ~i_drop_keepalive;
      o_proc_req <= ~(i_proc_sleep ^ i_pol_proc); // Level equals polarity when asleep
      o_peri_req <= ~(i_peri_sleep ^ i_pol_peri);
      o_scale_one <= i_scale[0];
      o_scale_two <= i_scale[1];
    end
  end
endmodule
`default_nettype wire

// File: pmc_pkg.sv
/*
  Shared constants for the power mode pin controller: APB register map,
  control field positions, reset values, state codes and tick counts.
  Assumes a 20 MHz reference clock and a 32.768 kHz crystal clock input.
*/
`default_nettype none
package pmc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SW1 = 8'h04;
  localparam logic [7:0] ADDR_SW2 = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_ISTAT = 8'h10;
  localparam logic [7:0] ADDR_IMASK = 8'h14;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int C_WDOG_COLD = 0;
  localparam int C_LPOFF_REQ = 1;
  localparam int C_MCU_GATE = 2;
  localparam int C_POL_PROC = 3;
  localparam int C_POL_PERI = 4;
  localparam int C_SID = 5;
  localparam int C_GENERAL_OUTPUT_FOUR_ADC = 6;
  localparam int C_OTG = 7;
  localparam int C_PRST_HOLD = 8;
  localparam int C_GENERAL_OUTPUT_FOUR = 9;
  localparam logic [9:0] CTRL_RST = 10'h018;
  localparam logic [11:0] SW_CFG_RST = 12'h000;
  localparam logic [5:0] LEVEL_RST = 6'h00;
  // ----------------------------------------------------------------
  // Interrupt bits and timing in 32 kHz ticks
  // ----------------------------------------------------------------
  localparam int I_WDOG = 0;
  localparam int I_STBY_IN = 1;
  localparam int I_STBY_OUT = 2;
  localparam int I_RAMP = 3;
  localparam int STEP_MV = 25;
  localparam int STEP_TICKS = 1;
  localparam int QUAL_TICKS = 2;
  localparam int START_TICKS = 8;
  localparam int WDOG_TICKS = 4;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_START = 3'b001,
    ST_ON = 3'b010,
    ST_STBY = 3'b011,
    ST_WDOG = 3'b100,
    ST_LPOFF = 3'b101,
    ST_COLD = 3'b110
  } pmc_state_t;
endpackage
`default_nettype wire

// File: pmc_qual.sv
/*
  Input qualifier: two-flop synchroniser then a stable-level check
  counted in 32 kHz ticks. Assumes i_tick is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_qual
  import pmc_pkg::*;
#(
  parameter int TICKS = QUAL_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_level,
  input wire logic i_tick,
  output logic o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic q;
  } pmc_qual_t;
  pmc_qual_t s, next_s;

  // First stage feeds only the second; level must hold TICKS ticks
  always_comb begin
    next_s = s;
    next_s.s1 = i_level;
    next_s.s2 = s.s1;
    if (s.s2 == s.q) begin
      next_s.cnt = 8'h00;
    end else if (i_tick) begin
      if (s.cnt == 8'(TICKS - 1)) begin
        next_s.q = s.s2;
        next_s.cnt = 8'h00;
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.q;
endmodule
`default_nettype wire

// File: pmc_ramp.sv
/*
  Output level ramp for one buck switcher: one code of 25 mV per
  time step toward the target. Assumes i_tick is a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_ramp
  import pmc_pkg::*;
#(
  parameter int STEPS = STEP_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic [5:0] i_target,
  output logic [5:0] o_level,
  output logic o_done
);
  typedef struct packed {
    logic [5:0] level;
    logic [7:0] cnt;
    logic done;
  } pmc_ramp_t;
  pmc_ramp_t s, next_s;

  // Never jump: a big change still walks one code per step
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.level == i_target) begin
      next_s.cnt = 8'h00;
    end else if (i_tick) begin
      if (s.cnt == 8'(STEPS - 1)) begin
        next_s.cnt = 8'h00;
        if (s.level < i_target) begin
          next_s.level = s.level + 6'h01;
        end else begin
          next_s.level = s.level - 6'h01;
        end
        next_s.done = (next_s.level == i_target);
      end else begin
        next_s.cnt = s.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '{level: LEVEL_RST, cnt: 8'h00, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.level;
  assign o_done = s.done;
endmodule
`default_nettype wire

// File: pmc_top.sv
/*
  Power mode pin controller: watchdog and low-power request handling,
  slow clock and reset outputs, power gate drivers, voltage scaling
  pins and boost feedback select, with an APB register slave.
  Assumes all pins synchronous to i_ref_clk (20 MHz) except the
  request and watchdog pins, which are synchronised here.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.
// Contract
// - Ramp voltage one 25 mV step per tick
// - Scaling pins reconfigurable as step up/down
// - Keepalive low leaves On to Off or Cold
// - Standby only when both requests asserted
// - Per-pin programmable polarity before combining
// - Synchronise and qualify request pins first
// - Requests honoured only in On mode
// - Peripheral slow clock driven from start-up
// - Peripheral slow clock only in Start, On and Standby states
// - Processor clock gateable in low-power off
// - Separate peripheral and processor resets
// - Fourth output can mux into ADC seven
// - OTG mode moves boost feedback to USB
// - Low-power off disables both gate drivers
`timescale 1ns/100ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_slow_clock_32k,
  input wire logic i_power_on_request,
  input wire logic i_watchdog_keepalive_input,
  input wire logic i_processor_low_power_request,
  input wire logic i_peripheral_low_power_request,
  input wire logic i_core_scaling_pin_one,
  input wire logic i_core_scaling_pin_two,
  output logic o_peripheral_slow_clock_out,
  output logic o_processor_slow_clock_out,
  output logic o_peripheral_reset_n_out,
  output logic o_processor_reset_n_out,
  output logic o_power_gate_driver_one,
  output logic o_power_gate_driver_two,
  output logic o_boost_feedback_usb_sel,
  output logic o_general_output_four,
  output logic o_general_output_four_adc7,
  output logic [5:0] o_buck_switcher_one_level,
  output logic [5:0] o_buck_switcher_two_level,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pmc_state_t st;
    logic [7:0] cnt;
    logic [9:0] ctrl;
    logic [11:0] sw1_cfg;
    logic [11:0] sw2_cfg;
    logic [5:0] step_up_down_mode;
    logic [3:0] ist;
    logic [3:0] imask;
    logic core_scaling_pin_one_d;
    logic core_scaling_pin_two_d;
    logic x32_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic pclk;
    logic mclk;
    logic prst_n;
    logic crst_n;
    logic pg;
    logic fb_usb;
    logic general_output_four;
    logic general_output_four_adc;
    logic irq;
  } pmc_top_t;
  pmc_top_t s, next_s;

  logic tick;
  logic wdi_q;
  logic proc_q;
  logic peri_q;
  logic stby_evt;
  logic [5:0] tgt1;
  logic [5:0] tgt2;
  logic [5:0] lvl1;
  logic [5:0] lvl2;
  logic done1;
  logic done2;

  // One pulse per rising edge of the crystal clock
  assign tick = i_slow_clock_32k & ~s.x32_d;

  // ----------------------------------------------------------------
  // Input qualification
  // ----------------------------------------------------------------
  pmc_qual u_q_wdi (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_level(i_watchdog_keepalive_input),
    .i_tick(tick),
    .o_level(wdi_q)
  );
  pmc_qual u_q_proc (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_level(i_processor_low_power_request),
    .i_tick(tick),
    .o_level(proc_q)
  );
  pmc_qual u_q_peri (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_level(i_peripheral_low_power_request),
    .i_tick(tick),
    .o_level(peri_q)
  );

  // Polarity first, then both must agree
  assign stby_evt = (proc_q ~^ s.ctrl[C_POL_PROC])
    & (peri_q ~^ s.ctrl[C_POL_PERI]);

  // ----------------------------------------------------------------
  // Switcher targets and ramps
  // ----------------------------------------------------------------
  // Pin high selects the scaled setpoint; step mode overrides switcher one
  always_comb begin
    tgt1 = i_core_scaling_pin_one ? s.sw1_cfg[11:6] : s.sw1_cfg[5:0];
    tgt2 = i_core_scaling_pin_two ? s.sw2_cfg[11:6] : s.sw2_cfg[5:0];
    if (s.ctrl[C_SID]) begin
      tgt1 = s.step_up_down_mode;
    end
  end

  pmc_ramp u_ramp1 (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_target(tgt1),
    .o_level(lvl1),
    .o_done(done1)
  );
  pmc_ramp u_ramp2 (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_tick(tick),
    .i_target(tgt2),
    .o_level(lvl2),
    .o_done(done2)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.x32_d = i_slow_clock_32k;
    next_s.core_scaling_pin_one_d = i_core_scaling_pin_one;
    next_s.core_scaling_pin_two_d = i_core_scaling_pin_two;
    // Step mode: pin one rises to step up, pin two to step down
    if (!s.ctrl[C_SID]) begin
      next_s.step_up_down_mode = s.sw1_cfg[5:0];
    end else if (i_core_scaling_pin_one && !s.core_scaling_pin_one_d && s.step_up_down_mode != 6'h3F) begin
      next_s.step_up_down_mode = s.step_up_down_mode + 6'h01;
    end else if (i_core_scaling_pin_two && !s.core_scaling_pin_two_d && s.step_up_down_mode != 6'h00) begin
      next_s.step_up_down_mode = s.step_up_down_mode - 6'h01;
    end
    // APB: one wait state, commit on the edge that sees pready
    next_s.pready = i_psel & i_penable & ~s.pready;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h0000_0000;
    if (i_psel && i_penable && !s.pready) begin
      unique case (i_paddr)
        ADDR_CTRL: next_s.prdata = {22'h00_0000, s.ctrl};
        ADDR_SW1: next_s.prdata = {20'h0_0000, s.sw1_cfg};
        ADDR_SW2: next_s.prdata = {20'h0_0000, s.sw2_cfg};
        ADDR_STAT: next_s.prdata = {5'h00, peri_q, proc_q, wdi_q, 2'h0,
                                    lvl2, 2'h0, lvl1, 5'h00, s.st};
        ADDR_ISTAT: next_s.prdata = {28'h000_0000, s.ist};
        ADDR_IMASK: next_s.prdata = {28'h000_0000, s.imask};
        default: next_s.pslverr = 1'b1;
      endcase
    end
    // Request bit is a command, stored for one cycle then cleared
    next_s.ctrl[C_LPOFF_REQ] = 1'b0;
    if (i_psel && i_penable && s.pready && i_pwrite) begin
      unique case (i_paddr)
        ADDR_CTRL: next_s.ctrl = i_pwdata[9:0];
        ADDR_SW1: next_s.sw1_cfg = i_pwdata[11:0];
        ADDR_SW2: next_s.sw2_cfg = i_pwdata[11:0];
        ADDR_ISTAT: next_s.ist = s.ist & ~i_pwdata[3:0];
        ADDR_IMASK: next_s.imask = i_pwdata[3:0];
        default: next_s.ist = next_s.ist;
      endcase
    end
    // Power mode sequencing
    unique case (s.st)
      ST_OFF: begin
        next_s.cnt = 8'h00;
        if (i_power_on_request) begin
          next_s.st = ST_START;
        end
      end
      ST_START: begin
        if (tick) begin
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt == 8'(START_TICKS - 1)) begin
            next_s.st = ST_ON;
            next_s.cnt = 8'h00;
          end
        end
      end
      ST_ON: begin
        if (!wdi_q) begin
          next_s.st = ST_WDOG;
          next_s.cnt = 8'h00;
          next_s.ist[I_WDOG] = 1'b1;
        end else if (s.ctrl[C_LPOFF_REQ]) begin
          next_s.st = ST_LPOFF;
        end else if (stby_evt) begin
          next_s.st = ST_STBY;
          next_s.ist[I_STBY_IN] = 1'b1;
        end
      end
      ST_STBY: begin
        if (!wdi_q) begin
          next_s.st = ST_WDOG;
          next_s.cnt = 8'h00;
          next_s.ist[I_WDOG] = 1'b1;
        end else if (!stby_evt) begin
          next_s.st = ST_ON;
          next_s.ist[I_STBY_OUT] = 1'b1;
        end
      end
      ST_WDOG: begin
        // Requests are ignored here; the drop always completes
        if (tick) begin
          next_s.cnt = s.cnt + 8'h01;
          if (s.cnt == 8'(WDOG_TICKS - 1)) begin
            next_s.st = s.ctrl[C_WDOG_COLD] ? ST_COLD : ST_OFF;
            next_s.cnt = 8'h00;
          end
        end
      end
      ST_LPOFF: begin
        if (i_power_on_request) begin
          next_s.st = ST_ON;
        end
      end
      ST_COLD: begin
        next_s.st = ST_START;
        next_s.cnt = 8'h00;
      end
      default: begin
        next_s.st = ST_OFF;
      end
    endcase
    // Ramp completion; set wins over a same-cycle clear
    if (done1 || done2) begin
      next_s.ist[I_RAMP] = 1'b1;
    end
    // Outputs follow the next state so pins change with it
    next_s.pclk = i_slow_clock_32k & (next_s.st == ST_START ||
      next_s.st == ST_ON || next_s.st == ST_STBY);
    next_s.mclk = i_slow_clock_32k & (next_s.st != ST_OFF) &
      (next_s.st != ST_COLD) &
      !(next_s.st == ST_LPOFF && next_s.ctrl[C_MCU_GATE]);
    next_s.crst_n = (next_s.st == ST_ON || next_s.st == ST_STBY ||
      next_s.st == ST_WDOG || next_s.st == ST_LPOFF);
    next_s.prst_n = next_s.crst_n & ~next_s.ctrl[C_PRST_HOLD];
    next_s.pg = (next_s.st == ST_ON || next_s.st == ST_STBY ||
      next_s.st == ST_WDOG);
    next_s.fb_usb = next_s.ctrl[C_OTG];
    next_s.general_output_four = next_s.ctrl[C_GENERAL_OUTPUT_FOUR] & ~next_s.ctrl[C_GENERAL_OUTPUT_FOUR_ADC];
    next_s.general_output_four_adc = next_s.ctrl[C_GENERAL_OUTPUT_FOUR_ADC];
    next_s.irq = |(next_s.ist & next_s.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
      s.st <= ST_OFF;
      s.ctrl <= CTRL_RST;
      s.sw1_cfg <= SW_CFG_RST;
      s.sw2_cfg <= SW_CFG_RST;
    end else begin
      s <= next_s;
    end
  end

  // Every output straight from a register: this state register, or the ramp registers for the levels
  assign o_prdata = s.prdata;
  assign o_pready = s.pready;
  assign o_pslverr = s.pslverr;
  assign o_peripheral_slow_clock_out = s.pclk;
  assign o_processor_slow_clock_out = s.mclk;
  assign o_peripheral_reset_n_out = s.prst_n;
  assign o_processor_reset_n_out = s.crst_n;
  assign o_power_gate_driver_one = s.pg;
  assign o_power_gate_driver_two = s.pg;
  assign o_boost_feedback_usb_sel = s.fb_usb;
  assign o_general_output_four = s.general_output_four;
  assign o_general_output_four_adc7 = s.general_output_four_adc;
  assign o_buck_switcher_one_level = lvl1;
  assign o_buck_switcher_two_level = lvl2;
  assign o_irq = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence on_with_event;
    s.st == ST_ON && wdi_q && !s.ctrl[C_LPOFF_REQ] && stby_evt;
  endsequence
  sequence in_stby;
    s.st == ST_STBY ##1 o_power_gate_driver_one;
  endsequence

  stby_entry_a: assert property (on_with_event |=> in_stby)
    else $error("standby not entered on event");
  stby_only_on_a: assert property (s.st == ST_STBY && $past(s.st) != ST_STBY
    |-> $past(s.st) == ST_ON)
    else $error("standby entered from wrong state");
  wdog_exit_a: assert property ((s.st == ST_ON || s.st == ST_STBY) && !wdi_q
    |=> s.st == ST_WDOG ##1 s.ist[I_WDOG])
    else $error("keepalive loss not handled");
  wdog_end_a: assert property (s.st == ST_WDOG && tick
    && s.cnt == 8'(WDOG_TICKS - 1)
    |=> s.st == ($past(s.ctrl[C_WDOG_COLD]) ? ST_COLD : ST_OFF))
    else $error("wrong watchdog destination");
  lpoff_gates_a: assert property (s.st == ST_LPOFF |->
    !o_power_gate_driver_one && !o_power_gate_driver_two)
    else $error("gate drivers on in low-power off");
  pclk_off_a: assert property (s.st == ST_OFF [*2] |->
    !o_peripheral_slow_clock_out)
    else $error("peripheral clock while off");
  mcu_gate_a: assert property (s.st == ST_LPOFF && s.ctrl[C_MCU_GATE]
    |-> !o_processor_slow_clock_out)
    else $error("processor clock not gated");
  rst_split_a: assert property (s.ctrl[C_PRST_HOLD] && s.st == ST_ON [*2]
    |-> o_processor_reset_n_out && !o_peripheral_reset_n_out)
    else $error("reset outputs not independent");
  fb_sel_a: assert property (##1 o_boost_feedback_usb_sel
    == $past(next_s.ctrl[C_OTG]))
    else $error("boost feedback select wrong");
  ramp_step_a: assert property (lvl1 != $past(lvl1) |->
    (lvl1 == $past(lvl1) + 6'h01 || lvl1 == $past(lvl1) - 6'h01))
    else $error("ramp moved more than one step");
endmodule
`default_nettype wire

// File: test_pmc_top.sv
/*
  Self-checking bench for the power mode pin controller.
  Assumes a 20 MHz reference clock and a free 32.768 kHz crystal.
*/
`timescale 1ns/100ps
`default_nettype none
module test_pmc_top;
  import pmc_pkg::*;
  localparam int TICK = 611;
  logic clk, rst, xtal, psel, pen, pwr, pready, pslverr, pon;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ka, rq_p, rq_s, sc1, sc2, pclk_o, mclk_o, prst_n, mrst_n;
  logic g1, g2, fb, out4, out4_adc, irq, drop, slp_p, slp_s, pol_p, pol_s, err;
  logic [1:0] scale;
  logic [5:0] lvl1, lvl2;
  int miscompares, n_tests, cyc, cnt_p, cnt_m;
  logic [9:0] cfg [3] = '{10'h218, 10'h258, 10'h098};
  logic [2:0] ex [3] = '{3'b100, 3'b010, 3'b001};
  // ----------------------------------------------------------------
  // Clocks, device and far end
  // ----------------------------------------------------------------
  always #25 clk = ~clk;
  always #15258.8 xtal = ~xtal;
  always @(posedge pclk_o) cnt_p++;
  always @(posedge mclk_o) cnt_m++;
  pmc_top pmc_top_inst (.i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_slow_clock_32k(xtal),
    .i_power_on_request(pon), .i_watchdog_keepalive_input(ka),
    .i_processor_low_power_request(rq_p), .i_peripheral_low_power_request(rq_s),
    .i_core_scaling_pin_one(sc1), .i_core_scaling_pin_two(sc2),
    .o_peripheral_slow_clock_out(pclk_o), .o_processor_slow_clock_out(mclk_o),
    .o_peripheral_reset_n_out(prst_n), .o_processor_reset_n_out(mrst_n),
    .o_power_gate_driver_one(g1), .o_power_gate_driver_two(g2),
    .o_boost_feedback_usb_sel(fb), .o_general_output_four(out4),
    .o_general_output_four_adc7(out4_adc), .o_buck_switcher_one_level(lvl1),
    .o_buck_switcher_two_level(lvl2), .o_irq(irq));
  pmc_far_end pmc_far_end_inst (.i_ref_clk(clk), .i_reset(rst), .i_drop_keepalive(drop),
    .i_proc_sleep(slp_p), .i_peri_sleep(slp_s), .i_pol_proc(pol_p), .i_pol_peri(pol_s),
    .i_scale(scale), .o_keepalive(ka), .o_proc_req(rq_p), .o_peri_req(rq_s),
    .o_scale_one(sc1), .o_scale_two(sc2));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held from setup until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rq, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) miscompares++; // A hung slave counts as a mismatch
    rq = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    logic e;
    apb(1'b0, a, 32'h0000_0000, rq, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic e;
    apb(1'b1, a, d, rq, e);
  endtask
  // Polls the state field; a bounded wait, not a fixed delay
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      rd(ADDR_STAT, q);
      n++;
    end while (q[2:0] !== s && n < 8000);
    chk(q[2:0], s);
  endtask
  // Slow clock outputs: toggling or still over about two ticks
  task automatic act(input logic pe, input logic me);
    int p0, m0;
    p0 = cnt_p;
    m0 = cnt_m;
    repeat (1300) @(posedge clk);
    chk({30'h0, cnt_p != p0, cnt_m != m0}, {30'h0, pe, me});
  endtask
  // Every change of the level is a single code
  task automatic ramp_to(input logic [5:0] t);
    logic [5:0] l;
    int n;
    l = lvl1;
    n = 0;
    while (lvl1 !== t && n < 20000) begin
      @(posedge clk);
      n++;
      if (lvl1 !== l) begin
        chk({31'h0, lvl1 == l + 6'd1 || lvl1 == l - 6'd1}, 32'h0000_0001);
        l = lvl1;
      end
    end
    chk(lvl1, t);
  endtask
  // ----------------------------------------------------------------
  // Timeout and main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    {clk, xtal, psel, pen, pwr, pon, drop, slp_p, slp_s, scale} = '0;
    {pol_p, pol_s, rst} = 3'b111;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, q);
    chk(q, 32'h0000_0018);
    apb(1'b0, 8'h40, 32'h0000_0000, q, err);
    chk({q[30:0], err}, 32'h0000_0001);
    chk({prst_n, mrst_n, g1, g2}, 32'h0000_0000);
    act(1'b0, 1'b0);
    pon <= 1'b1;
    wait_st(ST_START);
    pon <= 1'b0;
    act(1'b1, 1'b1);
    wait_st(ST_ON);
    chk({prst_n, mrst_n, g1, g2}, 32'h0000_000F);
    wr(ADDR_CTRL, 32'h0000_0118);
    repeat (3) @(posedge clk);
    chk({prst_n, mrst_n}, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, {22'h0, cfg[i]});
      repeat (3) @(posedge clk);
      chk({out4, out4_adc, fb}, ex[i]);
    end
    wr(ADDR_SW1, 32'h0000_0183);
    ramp_to(6'h03);
    scale <= 2'b01;
    ramp_to(6'h06);
    scale <= 2'b00;
    ramp_to(6'h03);
    wr(ADDR_SW2, 32'h0000_00C2);
    repeat (3 * TICK) @(posedge clk);
    chk(lvl2, 6'h02);
    rd(ADDR_ISTAT, q);
    chk(q[I_RAMP], 1'b1);
    wr(ADDR_CTRL, 32'h0000_0038);
    scale <= 2'b01;
    repeat (3 * TICK) @(posedge clk);
    scale <= 2'b00;
    chk(lvl1, 6'h04);
    @(posedge clk);
    scale <= 2'b10;
    repeat (3 * TICK) @(posedge clk);
    scale <= 2'b00;
    chk(lvl1, 6'h03);
    chk(lvl2, 6'h03);
    wr(ADDR_IMASK, 32'h0000_0002);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, {27'h0, p[1], p[0], 3'b000});
      pol_p <= p[0];
      pol_s <= p[1];
      wr(ADDR_ISTAT, 32'h0000_000F);
      slp_p <= 1'b1;
      repeat (4 * TICK) @(posedge clk);
      rd(ADDR_STAT, q);
      chk(q[2:0], ST_ON);
      slp_s <= 1'b1;
      wait_st(ST_STBY);
      chk(irq, 1'b1);
      {slp_p, slp_s} <= 2'b00;
      wait_st(ST_ON);
      rd(ADDR_ISTAT, q);
      chk(q[2:0], 3'b110);
      wr(ADDR_ISTAT, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    wr(ADDR_CTRL, 32'h0000_001E);
    wait_st(ST_LPOFF);
    repeat (2) @(posedge clk);
    chk({g1, g2}, 32'h0000_0000);
    act(1'b0, 1'b0);
    pon <= 1'b1;
    wait_st(ST_ON);
    pon <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0019);
    drop <= 1'b1;
    wait_st(ST_WDOG);
    drop <= 1'b0;
    wait_st(ST_START);
    wait_st(ST_ON);
    rd(ADDR_ISTAT, q);
    chk(q[I_WDOG], 1'b1);
    wr(ADDR_CTRL, 32'h0000_0018);
    drop <= 1'b1;
    wait_st(ST_WDOG);
    wait_st(ST_OFF);
    repeat (2) @(posedge clk);
    chk({prst_n, mrst_n, g1, g2}, 32'h0000_0000);
    close_out;
  end
endmodule
`default_nettype wire
